// ===== logic/nand_prot_pkg.sv
package nand_prot_pkg;

   // ----------------------------------------------------------------
   // clock and pin timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int T_STROBE_NS = 25;
   localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int T_WB_NS = 100;
   localparam int WB_CYC = (T_WB_NS * CLK_MHZ + 999) / 1000;
   localparam int SYNC_CYC = 2;
   localparam int READ_CYC = STROBE_CYC + SYNC_CYC;

   // ----------------------------------------------------------------
   // device command bytes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_RANGE_LOWER = 8'h23;
   localparam logic [7:0] CMD_RANGE_UPPER = 8'h24;
   localparam logic [7:0] CMD_PROTECT_ALL = 8'h2A;
   localparam logic [7:0] CMD_SEAL = 8'h2C;
   localparam logic [7:0] CMD_QUERY = 8'h7A;
   localparam logic [7:0] CMD_ERASE = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;

   // ----------------------------------------------------------------
   // protection status byte and device status byte fields
   // ----------------------------------------------------------------
   localparam int PSB_PROTECTED_N = 2;
   localparam int PSB_NOT_SEALED_FLAG = 1;
   localparam int PSB_SEALED_FLAG = 0;
   localparam int DSB_WRITE_OK = 7;

   // ----------------------------------------------------------------
   // controller register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_LOWER = 8'h04;
   localparam logic [7:0] REG_UPPER = 8'h08;
   localparam logic [7:0] REG_OP = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam int CTRL_WP_RELEASE = 0;
   localparam int UPPER_INVERT = 16;
   localparam int ST_BUSY = 0;
   localparam int ST_ERROR = 1;
   localparam int ST_NEED_RELEASE = 2;
   localparam int ST_READY_PIN = 3;
   localparam int ST_BLK_PROTECTED = 4;
   localparam int ST_SEALED = 5;
   localparam int ST_ERASE_REJECTED = 6;
   localparam int ST_BYTE_LSB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------
   // operations, sequence items, sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_RELEASE = 3'h0,
      OP_PROTECT_ALL = 3'h1,
      OP_SEAL = 3'h2,
      OP_QUERY = 3'h3,
      OP_ERASE = 3'h4
   } op_t;

   typedef enum logic [2:0] {
      IT_CMD = 3'h0,
      IT_ADDR = 3'h1,
      IT_READ = 3'h2,
      IT_WAIT = 3'h3,
      IT_END = 3'h4
   } item_t;

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_FETCH = 7'h02,
      S_WE_LOW = 7'h04,
      S_WE_HIGH = 7'h08,
      S_RE_LOW = 7'h10,
      S_RE_HIGH = 7'h20,
      S_WAIT = 7'h40
   } state_t;

endpackage : nand_prot_pkg

// ===== logic/sync_two_flop.sv
`timescale 1ns/1ps
module sync_two_flop #(
   parameter int WIDTH = 9
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_q <= '0;
         dout <= '0;
      end
      else
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end

endmodule : sync_two_flop

// ===== logic/ahb_reg_port.sv
`timescale 1ns/1ps
module ahb_reg_port (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic wrEn,
   output logic [7:0] wrAddr,
   output logic [31:0] wrData,
   output logic [7:0] rdAddr,
   input wire logic [31:0] rdData
);

   logic wrPend_q;
   logic [7:0] addr_q;
   logic take;

   // only whole-word transfers carry meaning; narrower sizes are accepted and ignored
   assign take = hsel && htrans[1] && hready && (hsize == 3'h2);
   assign rdAddr = haddr[7:0];
   assign wrEn = wrPend_q;
   assign wrAddr = addr_q;
   assign wrData = hwdata;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wrPend_q <= 1'b0;
         addr_q <= 8'h00;
         hrdata <= 32'h0000_0000;
      end
      else
      begin
         wrPend_q <= take && hwrite;
         addr_q <= haddr[7:0];
         if (take && !hwrite)
         begin
            hrdata <= rdData;
         end
      end
   end

   // zero wait states, always OKAY
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

endmodule : ahb_reg_port

// ===== logic/nand_prot_host.sv
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// RULE1 - copy-back program keeps cache; device side only
// RULE2 - strap low disables all protection commands
// RULE3 - strap high: all blocks start protected
// RULE4 - writes succeed only inside released range
// RULE5 - sealed state freezes protection until power cycle
// RULE6 - write-protect low protects all unsealed blocks
// RULE7 - after write-protect returns high, re-release range
// RULE8 - boundaries plus invert flag choose released blocks
// RULE9 - release: 23h lower address, 24h upper address
// RULE10 - page LSB carries invert, other page bits zero
// RULE11 - lower boundary strictly below upper boundary
// RULE12 - new release fully replaces old range
// RULE13 - address cycle layout: BA7:6, invert, BA15:8
// RULE14 - invert taken only after 24h
// RULE15 - 2Ah protects all unless strap low/sealed
// RULE16 - protected write: short busy, status bit7 cleared
// RULE17 - 2Ch seals and disables 23h and 2Ah
// RULE18 - confirm write-protect high before sealing
// RULE19 - blocks free at seal time stay writable
// RULE20 - power cycle after seal: all blocks protected
// RULE21 - 7Ah query: protection-format address, invert low
// RULE22 - status byte: line2 protected, lines1:0 seal state
// RULE23 - device checks row against protection before writing
module nand_prot_host (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic chipEnableN,
   output logic cmdLatch,
   output logic addrLatch,
   output logic writeStrobeN,
   output logic read_strobe_n,
   output logic writeProtectN,
   output logic [7:0] ioOut,
   output logic ioOeN,
   input wire logic [7:0] ioIn,
   input wire logic readyBusyN
);

   // ----------------------------------------------------------------
   // bus port and pin synchronisers
   // ----------------------------------------------------------------
   logic wrEn;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic [7:0] rdAddr;
   logic [31:0] rdData;
   logic [8:0] pinSync;
   logic [7:0] ioSync;
   logic rbSync;

   ahb_reg_port u_bus (
      .clk(clk),
      .arst_n(arst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .hresp(hresp),
      .wrEn(wrEn),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .rdAddr(rdAddr),
      .rdData(rdData)
   );

   sync_two_flop #(
      .WIDTH(9)
   ) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .din({readyBusyN, ioIn}),
      .dout(pinSync)
   );

   assign ioSync = pinSync[7:0];
   assign rbSync = pinSync[8];

   // ----------------------------------------------------------------
   // address cycle encoding
   // ----------------------------------------------------------------
   function automatic logic [7:0] firstCycle(input logic [15:0] blk, input logic inv);
      firstCycle = {blk[7:6], 5'h00, inv}; // [RULE13] [RULE10]
   endfunction : firstCycle

   function automatic logic [7:0] secondCycle(input logic [15:0] blk);
      secondCycle = blk[15:8]; // [RULE13]
   endfunction : secondCycle

   // step list of each operation: {item kind, byte}
   function automatic logic [10:0] seqItem(input nand_prot_pkg::op_t op, input logic [3:0] step,
                                           input logic [15:0] lo, input logic [15:0] up, input logic inv);
      seqItem = {nand_prot_pkg::IT_END, 8'h00};
      unique case (op)
         nand_prot_pkg::OP_RELEASE:
         begin
            unique case (step)
               4'h0: seqItem = {nand_prot_pkg::IT_CMD, nand_prot_pkg::CMD_RANGE_LOWER}; // [RULE9]
               4'h1: seqItem = {nand_prot_pkg::IT_ADDR, firstCycle(lo, 1'b0)}; // [RULE14]
               4'h2: seqItem = {nand_prot_pkg::IT_ADDR, secondCycle(lo)};
               4'h3: seqItem = {nand_prot_pkg::IT_CMD, nand_prot_pkg::CMD_RANGE_UPPER}; // [RULE9]
               4'h4: seqItem = {nand_prot_pkg::IT_ADDR, firstCycle(up, inv)}; // [RULE8] [RULE14]
               4'h5: seqItem = {nand_prot_pkg::IT_ADDR, secondCycle(up)};
               default: ;
            endcase
         end
         nand_prot_pkg::OP_PROTECT_ALL:
         begin
            if (step == 4'h0)
               seqItem = {nand_prot_pkg::IT_CMD, nand_prot_pkg::CMD_PROTECT_ALL}; // [RULE15]
         end
         nand_prot_pkg::OP_SEAL:
         begin
            if (step == 4'h0)
               seqItem = {nand_prot_pkg::IT_CMD, nand_prot_pkg::CMD_SEAL}; // [RULE17]
         end
         nand_prot_pkg::OP_QUERY:
         begin
            unique case (step)
               4'h0: seqItem = {nand_prot_pkg::IT_CMD, nand_prot_pkg::CMD_QUERY}; // [RULE21]
               4'h1: seqItem = {nand_prot_pkg::IT_ADDR, firstCycle(lo, 1'b0)}; // [RULE21]
               4'h2: seqItem = {nand_prot_pkg::IT_ADDR, secondCycle(lo)};
               4'h3: seqItem = {nand_prot_pkg::IT_READ, 8'h00};
               default: ;
            endcase
         end
         nand_prot_pkg::OP_ERASE:
         begin
            unique case (step)
               4'h0: seqItem = {nand_prot_pkg::IT_CMD, nand_prot_pkg::CMD_ERASE};
               4'h1: seqItem = {nand_prot_pkg::IT_ADDR, firstCycle(lo, 1'b0)};
               4'h2: seqItem = {nand_prot_pkg::IT_ADDR, secondCycle(lo)};
               4'h3: seqItem = {nand_prot_pkg::IT_CMD, nand_prot_pkg::CMD_ERASE_GO};
               4'h4: seqItem = {nand_prot_pkg::IT_WAIT, 8'h00}; // [RULE16]
               4'h5: seqItem = {nand_prot_pkg::IT_CMD, nand_prot_pkg::CMD_READ_STATUS};
               4'h6: seqItem = {nand_prot_pkg::IT_READ, 8'h00};
               default: ;
            endcase
         end
         default: ;
      endcase
   endfunction : seqItem

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   nand_prot_pkg::state_t state_q;
   nand_prot_pkg::op_t op_q;
   logic wpRelease_q;
   logic [15:0] lower_q;
   logic [16:0] upper_q;
   logic error_q;
   logic needRelease_q;
   logic [7:0] lastByte_q;
   logic blkProtected_q;
   logic sealed_q;
   logic eraseRejected_q;
   logic [3:0] step_q;
   logic [7:0] cnt_q;
   logic opWrite;
   logic startOk;
   logic refuse;
   logic [10:0] item;
   nand_prot_pkg::item_t itemKind;
   logic seqDone;

   assign opWrite = wrEn && (wrAddr == nand_prot_pkg::REG_OP) && (state_q == nand_prot_pkg::S_IDLE);
   // a bad range or a seal with write-protect still asserted never reaches the pins
   assign refuse = ((nand_prot_pkg::op_t'(wrData[2:0]) == nand_prot_pkg::OP_RELEASE)
                    && (lower_q >= upper_q[15:0])) // [RULE11]
                   || ((nand_prot_pkg::op_t'(wrData[2:0]) == nand_prot_pkg::OP_SEAL) && !wpRelease_q) // [RULE18]
                   || (wrData[2:0] > 3'h4);
   assign startOk = opWrite && !refuse;
   assign item = seqItem(op_q, step_q, lower_q, upper_q[15:0], upper_q[nand_prot_pkg::UPPER_INVERT]);
   assign itemKind = nand_prot_pkg::item_t'(item[10:8]);
   assign seqDone = (state_q == nand_prot_pkg::S_FETCH) && (itemKind == nand_prot_pkg::IT_END);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wpRelease_q <= nand_prot_pkg::CTRL_RESET[nand_prot_pkg::CTRL_WP_RELEASE];
         lower_q <= 16'h0000;
         upper_q <= 17'h0_0000;
      end
      else if (wrEn)
      begin
         if (wrAddr == nand_prot_pkg::REG_CTRL)
            wpRelease_q <= wrData[nand_prot_pkg::CTRL_WP_RELEASE];
         // boundaries are held stable while a sequence is on the pins
         if (wrAddr == nand_prot_pkg::REG_LOWER && state_q == nand_prot_pkg::S_IDLE)
            lower_q <= wrData[15:0];
         if (wrAddr == nand_prot_pkg::REG_UPPER && state_q == nand_prot_pkg::S_IDLE)
            upper_q <= wrData[16:0];
      end
   end

   // error is write-one-to-clear; a new refusal in the same cycle wins
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         error_q <= 1'b0;
      else if (opWrite && refuse)
         error_q <= 1'b1;
      else if (wrEn && wrAddr == nand_prot_pkg::REG_STATUS && wrData[nand_prot_pkg::ST_ERROR])
         error_q <= 1'b0;
   end

   // raising write-protect again leaves the device locked; flag it until a release completes
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         needRelease_q <= 1'b0;
      else if (wrEn && wrAddr == nand_prot_pkg::REG_CTRL && !wpRelease_q
               && wrData[nand_prot_pkg::CTRL_WP_RELEASE])
         needRelease_q <= 1'b1; // [RULE7]
      else if (seqDone && op_q == nand_prot_pkg::OP_RELEASE)
         needRelease_q <= 1'b0; // [RULE7] [RULE12]
   end

   // results of the last read cycle
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lastByte_q <= 8'h00;
         blkProtected_q <= 1'b0;
         sealed_q <= 1'b0;
         eraseRejected_q <= 1'b0;
      end
      else if (state_q == nand_prot_pkg::S_RE_LOW && cnt_q == 8'h00)
      begin
         lastByte_q <= ioSync;
         if (op_q == nand_prot_pkg::OP_QUERY)
         begin
            blkProtected_q <= !ioSync[nand_prot_pkg::PSB_PROTECTED_N]; // [RULE22]
            sealed_q <= ioSync[nand_prot_pkg::PSB_SEALED_FLAG]
                        && !ioSync[nand_prot_pkg::PSB_NOT_SEALED_FLAG]; // [RULE22]
         end
         else
         begin
            eraseRejected_q <= !ioSync[nand_prot_pkg::DSB_WRITE_OK]; // [RULE16]
         end
      end
   end

   always_comb
   begin
      rdData = 32'h0000_0000;
      unique case (rdAddr)
         nand_prot_pkg::REG_CTRL: rdData[nand_prot_pkg::CTRL_WP_RELEASE] = wpRelease_q;
         nand_prot_pkg::REG_LOWER: rdData[15:0] = lower_q;
         nand_prot_pkg::REG_UPPER: rdData[16:0] = upper_q;
         nand_prot_pkg::REG_STATUS:
         begin
            rdData[nand_prot_pkg::ST_BUSY] = (state_q != nand_prot_pkg::S_IDLE);
            rdData[nand_prot_pkg::ST_ERROR] = error_q;
            rdData[nand_prot_pkg::ST_NEED_RELEASE] = needRelease_q;
            rdData[nand_prot_pkg::ST_READY_PIN] = rbSync;
            rdData[nand_prot_pkg::ST_BLK_PROTECTED] = blkProtected_q;
            rdData[nand_prot_pkg::ST_SEALED] = sealed_q;
            rdData[nand_prot_pkg::ST_ERASE_REJECTED] = eraseRejected_q;
            rdData[nand_prot_pkg::ST_BYTE_LSB +: 8] = lastByte_q;
         end
         default: rdData = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // pin sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= nand_prot_pkg::S_IDLE;
         op_q <= nand_prot_pkg::OP_RELEASE;
         step_q <= 4'h0;
         cnt_q <= 8'h00;
         chipEnableN <= 1'b1;
         cmdLatch <= 1'b0;
         addrLatch <= 1'b0;
         writeStrobeN <= 1'b1;
         read_strobe_n <= 1'b1;
         ioOut <= 8'h00;
         ioOeN <= 1'b1;
      end
      else
      begin
         unique case (state_q)
            nand_prot_pkg::S_IDLE:
            begin
               if (startOk)
               begin
                  op_q <= nand_prot_pkg::op_t'(wrData[2:0]);
                  step_q <= 4'h0;
                  chipEnableN <= 1'b0;
                  state_q <= nand_prot_pkg::S_FETCH;
               end
            end
            nand_prot_pkg::S_FETCH:
            begin
               cmdLatch <= (itemKind == nand_prot_pkg::IT_CMD);
               addrLatch <= (itemKind == nand_prot_pkg::IT_ADDR);
               ioOut <= item[7:0];
               unique case (itemKind)
                  nand_prot_pkg::IT_CMD, nand_prot_pkg::IT_ADDR:
                  begin
                     ioOeN <= 1'b0;
                     writeStrobeN <= 1'b0;
                     cnt_q <= 8'(nand_prot_pkg::STROBE_CYC - 1);
                     state_q <= nand_prot_pkg::S_WE_LOW;
                  end
                  nand_prot_pkg::IT_READ:
                  begin
                     ioOeN <= 1'b1;
                     read_strobe_n <= 1'b0; // [RULE21]
                     cnt_q <= 8'(nand_prot_pkg::READ_CYC - 1);
                     state_q <= nand_prot_pkg::S_RE_LOW;
                  end
                  nand_prot_pkg::IT_WAIT:
                  begin
                     ioOeN <= 1'b1;
                     cnt_q <= 8'(nand_prot_pkg::WB_CYC - 1);
                     state_q <= nand_prot_pkg::S_WAIT;
                  end
                  nand_prot_pkg::IT_END:
                  begin
                     ioOeN <= 1'b1;
                     chipEnableN <= 1'b1;
                     state_q <= nand_prot_pkg::S_IDLE;
                  end
               endcase
            end
            nand_prot_pkg::S_WE_LOW:
            begin
               if (cnt_q == 8'h00)
               begin
                  writeStrobeN <= 1'b1;
                  cnt_q <= 8'(nand_prot_pkg::STROBE_CYC - 1);
                  state_q <= nand_prot_pkg::S_WE_HIGH;
               end
               else
                  cnt_q <= cnt_q - 8'h01;
            end
            nand_prot_pkg::S_RE_LOW:
            begin
               // the extra synchroniser cycles keep the sample inside the strobe
               if (cnt_q == 8'h00)
               begin
                  read_strobe_n <= 1'b1;
                  cnt_q <= 8'(nand_prot_pkg::STROBE_CYC - 1);
                  state_q <= nand_prot_pkg::S_RE_HIGH;
               end
               else
                  cnt_q <= cnt_q - 8'h01;
            end
            nand_prot_pkg::S_WE_HIGH, nand_prot_pkg::S_RE_HIGH:
            begin
               if (cnt_q == 8'h00)
               begin
                  step_q <= step_q + 4'h1;
                  state_q <= nand_prot_pkg::S_FETCH;
               end
               else
               begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            nand_prot_pkg::S_WAIT:
            begin
               // busy may not show until the delay has run; no fixed busy length is assumed
               if (cnt_q != 8'h00)
               begin
                  cnt_q <= cnt_q - 8'h01;
               end
               else if (rbSync)
               begin
                  step_q <= step_q + 4'h1; // [RULE16]
                  state_q <= nand_prot_pkg::S_FETCH;
               end
            end
            default:
            begin
               state_q <= nand_prot_pkg::S_IDLE;
               chipEnableN <= 1'b1;
               ioOeN <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         writeProtectN <= 1'b0;
      end
      else
      begin
         writeProtectN <= wpRelease_q; // [RULE6] [RULE18]
      end
   end

endmodule : nand_prot_host

// ===== verif/nand_prot_host_asserts.sv
`timescale 1ns/1ps
module nand_prot_host_asserts (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic chipEnableN,
   input wire logic cmdLatch,
   input wire logic addrLatch,
   input wire logic writeStrobeN,
   input wire logic read_strobe_n,
   input wire logic writeProtectN,
   input wire logic [7:0] ioOut,
   input wire logic ioOeN
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence cmd_s(logic [7:0] c);
      $fell(writeStrobeN) && cmdLatch && ioOut == c;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
   a_strobe_width: assert property ($fell(writeStrobeN) |-> !writeStrobeN [*5] ##1 writeStrobeN)
      else $error("write strobe width");
   a_drive_strobe: assert property (!writeStrobeN |-> !ioOeN && !chipEnableN) else $error("strobe undriven");
   a_read_release: assert property (!read_strobe_n |-> ioOeN && !chipEnableN)
      else $error("bus driven during read");
   a_seal_wp_high: assert property (cmd_s(8'h2C) |-> writeProtectN) else $error("seal with wp low");
   a_lower_inv: assert property (cmd_s(8'h23) |-> ##11 addrLatch && ioOut[5:0] == 6'h00)
      else $error("lower address cycle");
   a_upper_pad: assert property (cmd_s(8'h24) |-> ##11
      $fell(writeStrobeN) && addrLatch && ioOut[5:1] == 5'h00) else $error("upper address cycle");
   a_query_inv: assert property (cmd_s(8'h7A) |-> ##11 addrLatch && ioOut[5:0] == 6'h00)
      else $error("query address cycle");
   c_seal: cover property (cmd_s(8'h2C));
   c_upper: cover property (cmd_s(8'h24));
   c_read: cover property ($fell(read_strobe_n));
endmodule : nand_prot_host_asserts
bind nand_prot_host nand_prot_host_asserts u_chk (.*);

// ===== verif/nand_dev_model.sv
`timescale 1ns/1ps
module nand_dev_model #(
   parameter int BUSY_NS = 200
) (
   input wire logic power,
   input wire logic strap,
   input wire logic ceN,
   input wire logic cle,
   input wire logic ale,
   input wire logic weN,
   input wire logic reN,
   input wire logic wpN,
   input wire logic [7:0] io,
   output logic [7:0] dout,
   output logic rbN
);
   logic en, sealed, all, inv, iv;
   logic [15:0] lo, up, blk;
   logic [7:0] cmd, st, q;
   int n;
   function automatic logic prot(input logic [15:0] b);
      return en && (all || ((b >= lo && b <= up) == inv));
   endfunction : prot
   // a released bus shows the inverse, never a stale byte
   assign dout = reN ? ~q : q;
   always @(posedge power)
   begin
      en = strap;
      all = 1'b1;
      sealed = 1'b0;
      rbN = 1'b1;
      st = 8'h80;
      q = 8'h00;
   end
   always @(negedge wpN)
      if (en && !sealed) all = 1'b1;
   always @(negedge reN)
      if (!ceN) q = (cmd == 8'h70) ? st : {5'h0, !prot(blk), !sealed, sealed};
   always @(posedge weN)
      if (!ceN && cle)
      begin
         cmd = io;
         n = 0;
         if (io == 8'h2A && en && !sealed) all = 1'b1;
         if (io == 8'h2C && en) sealed = 1'b1;
         if (io == 8'hD0)
         begin
            st = prot(blk) ? 8'h00 : 8'h80;
            rbN = 1'b0;
            #(prot(blk) ? BUSY_NS : 2 * BUSY_NS) rbN = 1'b1;
         end
      end
      else if (!ceN && ale)
      begin
         if (n == 0) blk = {8'h0, io[7:6], 6'h0};
         if (n == 1) blk[15:8] = io;
         if (n == 0 && cmd == 8'h24) iv = io[0];
         n++;
         if (n == 2 && en && !sealed && cmd == 8'h23) lo = blk;
         if (n == 2 && en && !sealed && cmd == 8'h24)
         begin
            up = blk;
            inv = iv;
            all = 1'b0;
         end
      end
endmodule : nand_dev_model

// ===== verif/nand_prot_host_bench.sv
`timescale 1ns/1ps
module nand_prot_host_bench;
   logic clk, arst_n, hsel, hwrite, strap, hreadyout, hresp, chipEnableN, cmdLatch, addrLatch;
   logic writeStrobeN, read_strobe_n, writeProtectN, ioOeN, readyBusyN, eEn, eAll, eSealed, eInv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] ioOut, ioIn;
   logic [15:0] eLo, eUp, lo, up;
   logic [31:0] haddr, hwdata, hrdata, r, x;
   int failures, checks_done, cyc, seed = 898;
   nand_prot_host i_dut (.hready(hreadyout), .*);
   nand_dev_model i_dev (.power(arst_n), .strap(strap), .ceN(chipEnableN), .cle(cmdLatch), .ale(addrLatch),
      .weN(writeStrobeN), .reN(read_strobe_n), .wpN(writeProtectN), .io(ioOut), .dout(ioIn), .rbN(readyBusyN));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         failures++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus
   // keeps the final status word, then clears a sticky error
   task automatic op(input logic [2:0] c);
      bus(1'b1, 8'h0C, {29'h0, c});
      do bus(1'b0, 8'h10, 32'h0); while (r[0] !== 1'b0);
      x = r;
      bus(1'b1, 8'h10, 32'h2);
      r = x;
   endtask : op
   function automatic logic pexp(input logic [15:0] b);
      return eEn && (eAll || ((b >= eLo && b <= eUp) == eInv));
   endfunction : pexp
   task automatic probe(input logic [15:0] b);
      bus(1'b1, 8'h04, {16'h0, b});
      op(3'h3);
      chk(r[5:4], {eSealed, pexp(b)});
      op(3'h4);
      chk(r[6], pexp(b));
   endtask : probe
   task automatic rel(input logic [15:0] l, input logic [15:0] u, input logic v);
      bus(1'b1, 8'h04, {16'h0, l});
      bus(1'b1, 8'h08, {15'h0, v, u});
      op(3'h0);
      chk(r[1], l >= u);
      if (l < u && !eSealed)
      begin
         eLo = l;
         eUp = u;
         eInv = v;
         eAll = 1'b0;
      end
   endtask : rel
   task automatic power(input logic s);
      arst_n <= 1'b0;
      strap <= s;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      eEn = s;
      eAll = 1'b1;
      eSealed = 1'b0;
      bus(1'b1, 8'h00, 32'h1);
   endtask : power
   initial
   begin
      hsel = 1'b1;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      power(1'b1);
      probe(16'h0040);
      for (int i = 0; i < 4; i++)
      begin
         x = $random(seed);
         lo = {1'b0, x[14:6], 6'h0};
         up = lo + 16'h40 + {5'h0, x[20:16], 6'h0};
         rel(lo, up, x[24]);
         probe(lo);
         probe(up);
         probe(lo - 16'h40);
         probe(up + 16'h40);
         $display("range test %0d done", i);
      end
      rel(16'h0100, 16'h0100, 1'b0);
      op(3'h1);
      eAll = 1'b1;
      probe(16'h0100);
      rel(16'h0100, 16'h0400, 1'b0);
      bus(1'b1, 8'h00, 32'h0);
      eAll = 1'b1;
      op(3'h2);
      chk(r[1], 1'b1);
      bus(1'b1, 8'h00, 32'h1);
      bus(1'b0, 8'h10, 32'h0);
      chk(r[2], 1'b1);
      probe(16'h0200);
      rel(16'h0100, 16'h0400, 1'b1);
      op(3'h2);
      eSealed = 1'b1;
      op(3'h1);
      rel(16'h0000, 16'h0800, 1'b0);
      probe(16'h0200);
      probe(16'h0800);
      $display("seal test done");
      power(1'b1);
      probe(16'h0800);
      power(1'b0);
      op(3'h1);
      probe(16'h0800);
      $display("power test done");
      report_and_stop();
   end
endmodule : nand_prot_host_bench
